// ---- hw/ubcs_core.v ----
// Baud counters, FIFO status and event status registers of the serial port
//
// Contract
// R1: Transmit and receive baud counters are 17-bit, decrementing every clock.
// R2: Counter reloads divisor or half divisor at zero and on divisor write.
// R3: Receive counter loads half divisor when character sampling starts.
// R4: Receive count reads at 0x05C, transmit count at 0x060, live, read-only.
// R5: FIFO status at 0x008 is read-only; writes do nothing.
// R6: Bit 7 receiver idle; bit 6 transmit shift register empty.
// R7: Bits 5,3,2,0: transmit full, transmit empty, receive full, empty.
// R8: Bit 1 set when receive count is at or above receive threshold.
// R9: Event bit 4 follows transmit level condition.
// R10: Event status at 0x00C is read-only; writes ignored.
// R11: Bits 13..10 set on modem input change; cleared by read.
// R12: Bit 9 set when character counter reaches zero; cleared by read.
// R13: Bits 8..6 set on match 2..0; cleared by read.
// R14: Bit 5 set once per autoconfig completion; cleared by autoconfig read.
// R15: Bit 2 set on overrun; cleared by read.
// R16: Bit 1 set on parity error; cleared by read.
// R17: Event bit 0 follows receive level condition.
// R18: FIFO status bit 4 set when transmit count at or below threshold.
// R19: Bit 15 set once per bad autobaud measurement; cleared by read.
// R20: Bit 3 framing error, bit 14 break once per break; cleared by read.
`timescale 1ns/1ps
`include "ubcs_map.vh"
module ubcs_core #(
    parameter CNT_W  = `UBCS_CNT_W,
    parameter THLD_W = `UBCS_THLD_W,
    parameter LVL_W  = 6
) (
    input  wire              clk,
    input  wire              resetn,
    input  wire [7:0]        reg_addr,
    input  wire [31:0]       reg_wdata,
    input  wire              reg_wr,
    input  wire              reg_rd,
    output reg  [31:0]       reg_rdata,
    input  wire              rx_sample_start,
    input  wire              rx_half_load,
    input  wire              tx_half_load,
    input  wire              receiver_idle_flag,
    input  wire              shift_register_empty,
    input  wire              transmit_fifo_full,
    input  wire              transmit_fifo_empty,
    input  wire              receive_fifo_full,
    input  wire              receive_fifo_empty,
    input  wire [LVL_W-1:0]  rx_fifo_level,
    input  wire [LVL_W-1:0]  tx_fifo_level,
    input  wire [THLD_W-1:0] rx_threshold,
    input  wire [THLD_W-1:0] tx_threshold,
    input  wire [3:0]        modem_in,
    input  wire              char_count_zero,
    input  wire [2:0]        pattern_match_flags,
    input  wire              autoconfig_complete,
    input  wire              overrun_error,
    input  wire              parity_error,
    input  wire              framing_error,
    input  wire              break_seen,
    input  wire              autobaud_range_error,
    output reg  [CNT_W-1:0]  receive_bit_counter,
    output reg  [CNT_W-1:0]  transmit_bit_counter,
    output reg               rx_baud_tick,
    output reg               tx_baud_tick
);

    function [CNT_W-1:0] next_count;
        input [CNT_W-1:0] cur;
        input [CNT_W-1:0] div;
        input             reload;
        input             half;
        begin
            if (reload || cur == {CNT_W{1'b0}}) begin
                next_count = half ? (div >> 1) : div;
            end else begin
                next_count = cur - {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    endfunction

    reg  [CNT_W-1:0] divisor_reg;
    reg  [3:0]       modem_s1_reg;
    reg  [3:0]       modem_s2_reg;
    reg  [3:0]       modem_prev_reg;
    reg  [15:0]      event_reg;
    reg              break_prev_reg;
    reg              baud_err_prev_reg;
    reg              acfg_prev_reg;
    reg  [15:0]      event_next;
    reg  [31:0]      rdata_next;
    wire             div_wr;
    wire [CNT_W-1:0] div_load;
    wire             ev_rd;
    wire             acfg_rd;
    wire             rx_level_met;
    wire             tx_level_met;
    wire [7:0]       fifo_status;
    wire [3:0]       modem_change;

    assign div_wr  = reg_wr && reg_addr == `UBCS_OFF_DIVISOR;
    // A divisor write loads the counters with the value being written, or half of it when half load is set
    assign div_load = div_wr ? reg_wdata[CNT_W-1:0] : divisor_reg; // R2
    assign ev_rd   = reg_rd && reg_addr == `UBCS_OFF_EVENT_STATUS;
    assign acfg_rd = reg_rd && reg_addr == `UBCS_OFF_AUTOCONFIG;
    assign rx_level_met = {{(LVL_W-THLD_W){1'b0}}, rx_threshold}
                          <= rx_fifo_level; // R8
    assign tx_level_met = tx_fifo_level
                          <= {{(LVL_W-THLD_W){1'b0}}, tx_threshold}; // R18
    assign fifo_status = {receiver_idle_flag, shift_register_empty, // R6
                          transmit_fifo_full, tx_level_met,         // R7
                          transmit_fifo_empty, receive_fifo_full,
                          rx_level_met, receive_fifo_empty};
    assign modem_change = modem_s2_reg ^ modem_prev_reg;

    // Baud counters and divisor
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            divisor_reg          <= `UBCS_DIV_RESET;
            receive_bit_counter  <= {CNT_W{1'b0}};
            transmit_bit_counter <= {CNT_W{1'b0}};
            rx_baud_tick         <= 1'b0;
            tx_baud_tick         <= 1'b0;
        end else begin
            if (div_wr) begin
                divisor_reg <= reg_wdata[CNT_W-1:0];
            end
            receive_bit_counter <= next_count(receive_bit_counter,
                div_load, div_wr || rx_sample_start,
                rx_half_load || rx_sample_start); // R1 R2 R3
            transmit_bit_counter <= next_count(transmit_bit_counter,
                div_load, div_wr, tx_half_load); // R1 R2
            rx_baud_tick <= receive_bit_counter == {CNT_W{1'b0}};
            tx_baud_tick <= transmit_bit_counter == {CNT_W{1'b0}};
        end
    end

    // Events, sticky except level bits 0 and 4: a set in the clearing cycle wins
    always @* begin
        event_next = event_reg;
        if (ev_rd) begin
            event_next[15:6] = 10'h000;
            event_next[3:1]  = 3'h0;
        end
        if (acfg_rd) begin
            event_next[`UBCS_EV_AUTOCFG] = 1'b0; // R14
        end
        event_next[`UBCS_EV_RX_LEVEL] = rx_level_met; // R17
        event_next[`UBCS_EV_TX_LEVEL] = tx_level_met; // R9
        if (parity_error) event_next[`UBCS_EV_PARITY] = 1'b1; // R16
        if (overrun_error) event_next[`UBCS_EV_OVERRUN] = 1'b1; // R15
        if (framing_error) event_next[`UBCS_EV_FRAMING] = 1'b1; // R20
        if (autoconfig_complete && !acfg_prev_reg) begin
            event_next[`UBCS_EV_AUTOCFG] = 1'b1; // R14
        end
        event_next[8:6] = event_next[8:6] | pattern_match_flags; // R13
        if (char_count_zero) event_next[`UBCS_EV_CHAR_ZERO] = 1'b1; // R12
        event_next[13:10] = event_next[13:10] | modem_change; // R11
        if (break_seen && !break_prev_reg) begin
            event_next[`UBCS_EV_BREAK] = 1'b1; // R20
        end
        if (autobaud_range_error && !baud_err_prev_reg) begin
            event_next[`UBCS_EV_AUTOBAUD] = 1'b1; // R19
        end
    end

    // Read mux; unmapped addresses read zero
    always @* begin
        case (reg_addr)
            `UBCS_OFF_FIFO_STATUS:  rdata_next = {24'h00_0000, fifo_status};
            `UBCS_OFF_EVENT_STATUS: rdata_next = {16'h0000, event_reg};
            `UBCS_OFF_DIVISOR:
                rdata_next = {{(32-CNT_W){1'b0}}, divisor_reg};
            `UBCS_OFF_RX_COUNT:
                rdata_next = {{(32-CNT_W){1'b0}}, receive_bit_counter}; // R4
            `UBCS_OFF_TX_COUNT:
                rdata_next = {{(32-CNT_W){1'b0}}, transmit_bit_counter}; // R4
            `UBCS_OFF_AUTOCONFIG:
                rdata_next = {31'h0000_0000, event_reg[`UBCS_EV_AUTOCFG]};
            default:                rdata_next = 32'h0000_0000;
        endcase
    end

    // Status writes are not decoded, so they have no effect
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata         <= 32'h0000_0000;
            event_reg         <= 16'h0000;
            modem_s1_reg      <= 4'h0;
            modem_s2_reg      <= 4'h0;
            modem_prev_reg    <= 4'h0;
            break_prev_reg    <= 1'b0;
            baud_err_prev_reg <= 1'b0;
            acfg_prev_reg     <= 1'b0;
        end else begin
            reg_rdata         <= reg_rd ? rdata_next : 32'h0000_0000;
            event_reg         <= event_next; // R5 R10
            modem_s1_reg      <= modem_in;
            modem_s2_reg      <= modem_s1_reg;
            modem_prev_reg    <= modem_s2_reg;
            break_prev_reg    <= break_seen;
            baud_err_prev_reg <= autobaud_range_error;
            acfg_prev_reg     <= autoconfig_complete;
        end
    end

endmodule

// ---- hw/ubcs_map.vh ----
// Register offsets, field positions and reset values for the baud/status block
`ifndef UBCS_MAP_VH
`define UBCS_MAP_VH
`define UBCS_OFF_FIFO_STATUS   8'h08
`define UBCS_OFF_EVENT_STATUS  8'h0c
`define UBCS_OFF_DIVISOR       8'h20
`define UBCS_OFF_RX_COUNT      8'h5c
`define UBCS_OFF_TX_COUNT      8'h60
`define UBCS_OFF_AUTOCONFIG    8'h64
`define UBCS_CNT_W             17
`define UBCS_DIV_RESET         17'h0_0000
`define UBCS_THLD_W            5
`define UBCS_EV_RX_LEVEL       0
`define UBCS_EV_PARITY         1
`define UBCS_EV_OVERRUN        2
`define UBCS_EV_FRAMING        3
`define UBCS_EV_TX_LEVEL       4
`define UBCS_EV_AUTOCFG        5
`define UBCS_EV_MATCH_LO       6
`define UBCS_EV_CHAR_ZERO      9
`define UBCS_EV_MODEM_LO       10
`define UBCS_EV_BREAK          14
`define UBCS_EV_AUTOBAUD       15
`endif

// ---- test/ubcs_props.sv ----
// Assertion checker for the baud counter and status block
`timescale 1ns/1ps
module ubcs_props #(parameter CNT_W = 17) (
    input wire             clk,
    input wire             resetn,
    input wire [7:0]       reg_addr,
    input wire             reg_wr,
    input wire             reg_rd,
    input wire [31:0]      reg_rdata,
    input wire             rx_sample_start,
    input wire             parity_error,
    input wire [CNT_W-1:0] receive_bit_counter,
    input wire [CNT_W-1:0] transmit_bit_counter
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wire div_wr = reg_wr && reg_addr == 8'h20;
    wire ev_rd  = reg_rd && reg_addr == 8'h0c;
    wire rx_run = receive_bit_counter != 0 && !rx_sample_start && !div_wr;
    wire tx_run = transmit_bit_counter != 0 && !div_wr;
    property p_rx_dec; rx_run |=>
        receive_bit_counter == $past(receive_bit_counter) - 1; endproperty
    a_rx_dec: assert property (p_rx_dec) else $error("rx step");
    property p_tx_dec; tx_run |=>
        transmit_bit_counter == $past(transmit_bit_counter) - 1; endproperty
    a_tx_dec: assert property (p_tx_dec) else $error("tx step");
    property p_rx_rd; reg_rd && reg_addr == 8'h5c |=>
        reg_rdata == 32'($past(receive_bit_counter)); endproperty
    a_rx_rd: assert property (p_rx_rd) else $error("rx read");
    property p_tx_rd; reg_rd && reg_addr == 8'h60 |=>
        reg_rdata == 32'($past(transmit_bit_counter)); endproperty
    a_tx_rd: assert property (p_tx_rd) else $error("tx read");
    property p_idle; !reg_rd |=> reg_rdata == 32'h0000_0000; endproperty
    a_idle: assert property (p_idle) else $error("rdata idle");
    property p_fifo_hi; reg_rd && reg_addr == 8'h08 |=>
        reg_rdata[31:8] == 24'h00_0000; endproperty
    a_fifo_hi: assert property (p_fifo_hi) else $error("fifo high");
    property p_par_set; parity_error ##1 !ev_rd [*7] ##1 ev_rd |=>
        reg_rdata[1]; endproperty
    a_par_set: assert property (p_par_set) else $error("par set");
    property p_par_clr; ev_rd && !parity_error ##1 !parity_error ##1 ev_rd
        |=> !reg_rdata[1]; endproperty
    a_par_clr: assert property (p_par_clr) else $error("par clr");
endmodule
bind ubcs_core ubcs_props #(.CNT_W(CNT_W)) chk_u (.clk, .resetn, .reg_addr,
    .reg_wr, .reg_rd, .reg_rdata, .rx_sample_start, .parity_error,
    .receive_bit_counter, .transmit_bit_counter);

// ---- test/ubcs_far_model.sv ----
// Far-side model driving the four modem status pins
`timescale 1ns/1ps
module ubcs_far_model (
    input  wire       clk,
    input  wire [3:0] toggle,
    output reg  [3:0] modem_in
);
    initial modem_in = 4'h0;
    always @(posedge clk)
        modem_in <= modem_in ^ toggle;
endmodule

// ---- test/ubcs_core_tb_top.sv ----
// Testbench for the baud counter and status block
`timescale 1ns/1ps
module ubcs_core_tb_top;
    logic clk, resetn, reg_wr, reg_rd, rx_sample_start, rx_half_load;
    logic tx_half_load, receiver_idle_flag, shift_register_empty;
    logic transmit_fifo_full, transmit_fifo_empty, receive_fifo_full;
    logic receive_fifo_empty, char_count_zero, autoconfig_complete;
    logic overrun_error, parity_error, framing_error, break_seen;
    logic autobaud_range_error;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic [2:0] pattern_match_flags;
    logic [5:0] rx_fifo_level, tx_fifo_level;
    logic [4:0] rx_threshold, tx_threshold;
    logic [3:0] toggle;
    wire [3:0] modem_in;
    wire [31:0] reg_rdata;
    wire [16:0] receive_bit_counter, transmit_bit_counter;
    wire rx_baud_tick, tx_baud_tick;
    int n_errors = 0, check_count = 0, cycles = 0;
    ubcs_core dut_u (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .rx_sample_start, .rx_half_load, .tx_half_load,
        .receiver_idle_flag, .shift_register_empty, .transmit_fifo_full,
        .transmit_fifo_empty, .receive_fifo_full, .receive_fifo_empty,
        .rx_fifo_level, .tx_fifo_level, .rx_threshold, .tx_threshold,
        .modem_in, .char_count_zero, .pattern_match_flags,
        .autoconfig_complete, .overrun_error, .parity_error, .framing_error,
        .break_seen, .autobaud_range_error, .receive_bit_counter,
        .transmit_bit_counter, .rx_baud_tick, .tx_baud_tick);
    ubcs_far_model far_u (.clk, .toggle, .modem_in);
    task finish_test;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask
    task t_count;
        wr(8'h20, 32'h0000_0009);
        repeat (40) begin
            @(posedge clk);
            #1;
            if (transmit_bit_counter == 17'h0_0000)
                break;
        end
        @(posedge clk);
        #1;
        chk(32'(transmit_bit_counter), 32'h0000_0009);
        chk(32'(tx_baud_tick), 32'h0000_0001);
        chk(32'(rx_baud_tick), 32'h0000_0001);
        @(posedge clk);
        rx_sample_start <= 1'b1;
        @(posedge clk);
        rx_sample_start <= 1'b0;
        #1;
        chk(32'(receive_bit_counter), 32'h0000_0004);
        chk(32'(tx_baud_tick), 32'h0000_0000);
        rd(8'h5c, 32'h0000_0003);
        rd(8'h60, 32'h0000_0004);
    endtask
    task t_half;
        @(posedge clk);
        rx_half_load <= 1'b0;
        tx_half_load <= 1'b1;
        wr(8'h20, 32'h0000_0009);
        #1;
        chk(32'(receive_bit_counter), 32'h0000_0009);
        chk(32'(transmit_bit_counter), 32'h0000_0004);
        repeat (20) begin
            @(posedge clk);
            #1;
            if (transmit_bit_counter == 17'h0_0000)
                break;
        end
        @(posedge clk);
        #1;
        chk(32'(transmit_bit_counter), 32'h0000_0004);
        chk(32'(receive_bit_counter), 32'h0000_0004);
        @(posedge clk);
        rx_half_load <= 1'b1;
        tx_half_load <= 1'b0;
    endtask
    task t_status;
        @(posedge clk);
        {receiver_idle_flag, shift_register_empty, transmit_fifo_full,
            transmit_fifo_empty, receive_fifo_full,
            receive_fifo_empty} <= 6'h2c;
        tx_fifo_level <= 6'h05;
        tx_threshold <= 5'h04;
        rx_fifo_level <= 6'h04;
        rx_threshold <= 5'h04;
        wr(8'h08, 32'hffff_ffff);
        rd(8'h08, 32'h0000_00aa);
    endtask
    task t_events;
        @(posedge clk);
        {char_count_zero, overrun_error, parity_error, framing_error} <= 4'hf;
        pattern_match_flags <= 3'h7;
        {autoconfig_complete, break_seen, autobaud_range_error} <= 3'h7;
        toggle <= 4'hf;
        @(posedge clk);
        {char_count_zero, overrun_error, parity_error, framing_error} <= 4'h0;
        pattern_match_flags <= 3'h0;
        toggle <= 4'h0;
        repeat (4) @(posedge clk);
        wr(8'h0c, 32'h0000_0000);
        rd(8'h0c, 32'h0000_ffef);
        rd(8'h0c, 32'h0000_0021);
        rd(8'h64, 32'h0000_0001);
        rd(8'h0c, 32'h0000_0001);
        rd(8'h7c, 32'h0000_0000);
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            n_errors++;
            finish_test;
        end
    end
    initial begin
        {resetn, reg_wr, reg_rd, rx_sample_start, tx_half_load, reg_addr,
            reg_wdata, receiver_idle_flag, shift_register_empty,
            transmit_fifo_full, transmit_fifo_empty, receive_fifo_full,
            receive_fifo_empty, char_count_zero, autoconfig_complete,
            overrun_error, parity_error, framing_error, break_seen,
            autobaud_range_error, pattern_match_flags, rx_fifo_level,
            tx_fifo_level, rx_threshold, tx_threshold, toggle} = '0;
        rx_half_load = 1'b1;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        t_count;
        t_half;
        t_status;
        t_events;
        finish_test;
    end
endmodule
